// ===== rtl/bfc_pkg.sv
package bfc_pkg;
   // Register identifiers in the internal register space
   localparam logic [7:0] ID_HIST_READ = 8'h18;
   localparam logic [7:0] ID_PROC_CFG = 8'h1b;
   // Node I/O space: first address of slot n is base plus n strides
   localparam logic [31:0] IO_BASE = 32'h2000_0000;
   localparam logic [31:0] NODE_STRIDE = 32'h0000_2000;
   localparam int NODE_SPACE_LSB = 13;
   localparam int PHYS_MSB = 29;
   // Command/address cycle: function in data 31:28, longword address below
   localparam int FUNC_MSB = 31;
   localparam int FUNC_LSB = 28;
   localparam int CA_ADDR_MSB = 27;
   localparam int CA_ADDR_LSB = 11;
   // Status bits in both configuration/status registers; history valid bit 16 in the configuration register only
   localparam int CSR_PAR = 31;
   localparam int CSR_WSQ = 30;
   localparam int CSR_URD = 29;
   localparam int CSR_ISQ = 28;
   localparam int CSR_MXT = 27;
   localparam int CSR_TXF = 26;
   localparam int CSR_HVALID = 16;
   localparam int NFLT = 6;
   // History entry layout
   localparam int H_TAG_LSB = 29;
   localparam int H_ID_LSB = 24;
   localparam int H_MASK_LSB = 18;
   localparam int H_CNF_LSB = 16;
   localparam int H_REQ_LSB = 0;
   localparam int HIST_DEPTH = 16;
   // Cycle tags
   localparam logic [2:0] TAG_RDATA = 3'h0;
   localparam logic [2:0] TAG_CMDADR = 3'h3;
   localparam logic [2:0] TAG_WDATA = 3'h5;
   localparam logic [2:0] TAG_RDATA_ALT = 3'h6;
   // Command function codes
   localparam logic [3:0] FN_READ = 4'h1;
   localparam logic [3:0] FN_WRITE = 4'h2;
   localparam logic [3:0] FN_ILK_READ = 4'h4;
   localparam logic [3:0] FN_ILK_WRITE = 4'h7;
   localparam logic [3:0] FN_EXT_READ = 4'h8;
   localparam logic [3:0] FN_EXT_WRITE = 4'hb;
   localparam logic [1:0] WR_DATA_CYCLES = 2'h1;
   localparam logic [1:0] EXT_WR_DATA_CYCLES = 2'h2;
   // Read data mask codes
   localparam logic [3:0] MASK_GOOD = 4'h0;
   localparam logic [3:0] MASK_CORRECTED = 4'h1;
   localparam logic [3:0] MASK_BAD = 4'h2;
   // Confirmation codes
   localparam logic [1:0] CNF_NONE = 2'h0;
   localparam logic [1:0] CNF_ACK = 2'h1;
   localparam logic [1:0] CNF_BUSY = 2'h2;
   localparam logic [1:0] CNF_ERROR = 2'h3;
   // Capture state: armed then frozen
   typedef enum logic [1:0] {
      CAP_ARMED = 2'b00,
      CAP_FROZEN = 2'b01
   } bfc_cap_t;
endpackage

// ===== rtl/bfc_fault_detect.sv
`timescale 1ns/10ps
`default_nettype none
module bfc_fault_detect #(
   parameter int NODE_SLOT = 1
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [2:0] busTag,
   input wire logic [4:0] busId,
   input wire logic [3:0] busMask,
   input wire logic [31:0] busData,
   input wire logic [1:0] busParity,
   input wire logic [4:0] myIdSent,
   input wire logic myTransmitting,
   input wire logic [4:0] myId,
   input wire logic readWaiting,
   input wire logic busyIn,
   output logic cmdHit,
   output logic funcOk,
   output logic [4:0] faults
);
   localparam logic [31:0] NODE_BASE = 32'(bfc_pkg::IO_BASE + NODE_SLOT * bfc_pkg::NODE_STRIDE);
   logic [1:0] wrLeft_q, wrLeft_d;
   logic interlock_q, interlock_d;
   logic [3:0] func;
   logic isCa, accept, isWrite;

   // Command decode and function support
   always_comb begin
      func = busData[bfc_pkg::FUNC_MSB:bfc_pkg::FUNC_LSB];
      isCa = (busTag == bfc_pkg::TAG_CMDADR);
      cmdHit = isCa && (busData[bfc_pkg::CA_ADDR_MSB:bfc_pkg::CA_ADDR_LSB]
               == NODE_BASE[bfc_pkg::PHYS_MSB:bfc_pkg::NODE_SPACE_LSB]);
      funcOk = (func == bfc_pkg::FN_READ) || (func == bfc_pkg::FN_WRITE) ||
               (func == bfc_pkg::FN_ILK_READ) || (func == bfc_pkg::FN_ILK_WRITE) ||
               (func == bfc_pkg::FN_EXT_READ) || (func == bfc_pkg::FN_EXT_WRITE);
      accept = cmdHit && funcOk && !busyIn;
      isWrite = (func == bfc_pkg::FN_WRITE) || (func == bfc_pkg::FN_ILK_WRITE) ||
                (func == bfc_pkg::FN_EXT_WRITE);
   end

   // Fault detection and sequence tracking
   always_comb begin
      wrLeft_d = wrLeft_q;
      interlock_d = interlock_q;
      faults = '0;
      // Even parity over each group including its parity line
      faults[4] = (^{busTag, busId, busMask, busParity[0]}) | (^{busData, busParity[1]}); // [RULE19]
      // Write data must follow an accepted write command at once
      if (wrLeft_q != 2'h0) begin
         if (busTag != bfc_pkg::TAG_WDATA) begin
            faults[3] = 1'b1; // [RULE20]
            wrLeft_d = 2'h0;
         end else begin
            wrLeft_d = wrLeft_q - 2'h1;
         end
      end
      if (accept && isWrite) begin
         wrLeft_d = (func == bfc_pkg::FN_EXT_WRITE) ? bfc_pkg::EXT_WR_DATA_CYCLES
                                                   : bfc_pkg::WR_DATA_CYCLES;
      end
      faults[2] = ((busTag == bfc_pkg::TAG_RDATA) || (busTag == bfc_pkg::TAG_RDATA_ALT)) &&
                  (busId == myId) && !readWaiting;
      // Interlock write without a prior interlock read
      if (accept && func == bfc_pkg::FN_ILK_READ) begin
         interlock_d = 1'b1;
      end
      if (accept && func == bfc_pkg::FN_ILK_WRITE) begin
         faults[1] = !interlock_q; // [RULE21]
         interlock_d = 1'b0;
      end
      // Our first-phase identifier must come back unchanged
      faults[0] = myTransmitting && (myIdSent != busId); // [RULE22]
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wrLeft_q <= 2'h0;
         interlock_q <= 1'b0;
      end else begin
         wrLeft_q <= wrLeft_d;
         interlock_q <= interlock_d;
      end
   end

   a_wseq_missing: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE20]
      (accept && func == bfc_pkg::FN_WRITE) ##1 (busTag != bfc_pkg::TAG_WDATA) |-> faults[3])
      else $error("missing write data not flagged");
   a_ilk_fault: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE21]
      (accept && func == bfc_pkg::FN_ILK_WRITE && !interlock_q) |-> faults[1])
      else $error("interlock sequence fault missed");
endmodule
`default_nettype wire

// ===== rtl/bfc_history.sv
`timescale 1ns/10ps
`default_nettype none
module bfc_history #(
   parameter int DEPTH = bfc_pkg::HIST_DEPTH,
   parameter int WIDTH = 32
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] entryIn,
   input wire logic wrEn,
   input wire logic pop,
   input wire logic rearm,
   output logic [WIDTH-1:0] rdData,
   output logic filled
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] PTR_ONE = AW'(1);
   localparam logic [AW:0] FILL_FULL = (AW + 1)'(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [AW:0] fill_q, fill_d;

   // Ring storage, one flop row per entry
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_comb begin
         mem_d[i] = mem_q[i];
         if (wrEn && wrPtr_q == AW'(i)) begin
            mem_d[i] = entryIn; // [RULE6]
         end
      end
      always_ff @(posedge core_clk) begin
         mem_q[i] <= mem_d[i];
      end
   end

   // Pointers: read pointer trails onto the oldest entry
   always_comb begin
      wrPtr_d = wrEn ? wrPtr_q + PTR_ONE : wrPtr_q;
      fill_d = fill_q;
      if (rearm) begin
         fill_d = '0;
      end else if (wrEn && fill_q != FILL_FULL) begin
         fill_d = fill_q + 1'b1;
      end
      if (wrEn || rearm) begin
         rdPtr_d = wrPtr_d; // Oldest slot once the ring is full [RULE8]
      end else if (pop) begin
         rdPtr_d = rdPtr_q + PTR_ONE; // [RULE7]
      end else begin
         rdPtr_d = rdPtr_q;
      end
      rdData = mem_q[rdPtr_q];
      filled = (fill_q == FILL_FULL);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         fill_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         fill_q <= fill_d;
      end
   end

   a_pop_advance: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE7]
      (pop && !wrEn && !rearm) |=> (rdPtr_q == $past(rdPtr_q) + PTR_ONE))
      else $error("history read did not advance");
endmodule
`default_nettype wire

// ===== rtl/bfc_capture.sv
// What this block does
// [RULE1] Fault latches six status bits 31:26
// [RULE2] Bits 31,30,29: parity, write sequence, read
// [RULE3] Bits 28,27: interlock, multi transmit; 26 transmitting
// [RULE4] Same layout; undetectable faults read zero
// [RULE5] Status at node base plus slot stride
// [RULE6] Sixteen-entry bus history frozen on fault
// [RULE7] One register returns next entry per read
// [RULE8] History read out oldest entry first
// [RULE9] Identifier: source if tag nonzero, else destination
// [RULE10] Command function codes recorded on command cycles
// [RULE11] Mask lines in 21:18; read data codes
// [RULE12] Read mask code 2 means bad data
// [RULE13] Write data tag 5 mask picks bytes
// [RULE14] Confirm code two cycles later, bits 17:16
// [RULE15] Confirm 0 none, 1 acknowledge
// [RULE16] Confirm 2 busy, 3 cannot perform
// [RULE17] Bits 15:0 record arbitration request lines
// [RULE18] Config bit 16 set when history valid
// [RULE19] Even parity over header and data groups
// [RULE20] Missing write data flags write sequence fault
// [RULE21] Interlock write without lock flags fault
// [RULE22] Sent versus received identifier mismatch flags
// [RULE23] Captured record held until software clears
`timescale 1ns/10ps
`default_nettype none
module bfc_capture #(
   parameter int NODE_SLOT = 1,
   parameter logic [5:0] FAULT_IMPL = 6'h3f
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [2:0] busTag,
   input wire logic [4:0] busId,
   input wire logic [3:0] busMask,
   input wire logic [31:0] busData,
   input wire logic [1:0] busParity,
   input wire logic [1:0] busConfirm,
   input wire logic [15:0] busReq,
   input wire logic busFaultIn,
   input wire logic [4:0] myId,
   input wire logic [4:0] myIdSent,
   input wire logic myTransmitting,
   input wire logic readWaiting,
   input wire logic busyIn,
   input wire logic regRd,
   input wire logic regWr,
   input wire logic regIdSpace,
   input wire logic [31:0] regAddr,
   input wire logic [31:0] regWdata,
   output logic [31:0] regRdata,
   output logic regRvalid,
   output logic faultOut,
   output logic [1:0] confirmOut,
   output logic histValid
);
   localparam logic [31:0] NODE_BASE = 32'(bfc_pkg::IO_BASE + NODE_SLOT * bfc_pkg::NODE_STRIDE);
   localparam logic [7:0] ID_MASK = 8'hff;
   bfc_pkg::bfc_cap_t state_q, state_d;
   logic [5:0] flt_q, flt_d;
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic faultOut_q, faultOut_d;
   logic [1:0] cnfPipe_q, cnfPipe_d, cnf_q, cnf_d;
   logic [29:0] entA_q, entA_d, entB_q, entB_d;
   logic [1:0] prime_q, prime_d;
   logic histValid_q, histValid_d;
   logic cmdHit, funcOk, filled, histWr, pop, rearm, faultNow, selCsr, selCfg, selHist;
   logic [4:0] faults;
   logic [31:0] histData, entry, csrWord;
   logic [5:0] w1c;

   bfc_fault_detect #(.NODE_SLOT(NODE_SLOT)) u_det (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .busTag(busTag),
      .busId(busId),
      .busMask(busMask),
      .busData(busData),
      .busParity(busParity),
      .myIdSent(myIdSent),
      .myTransmitting(myTransmitting),
      .myId(myId),
      .readWaiting(readWaiting),
      .busyIn(busyIn),
      .cmdHit(cmdHit),
      .funcOk(funcOk),
      .faults(faults)
   );

   bfc_history #(.DEPTH(bfc_pkg::HIST_DEPTH), .WIDTH(32)) u_hist (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .entryIn(entry),
      .wrEn(histWr),
      .pop(pop),
      .rearm(rearm),
      .rdData(histData),
      .filled(filled)
   );

   // Register decode: node address space or internal register numbers
   always_comb begin
      selCsr = !regIdSpace && (regAddr == NODE_BASE); // [RULE5]
      selCfg = regIdSpace && ((regAddr & 32'(ID_MASK)) == 32'(bfc_pkg::ID_PROC_CFG))
               && (regAddr[31:8] == '0);
      selHist = regIdSpace && ((regAddr & 32'(ID_MASK)) == 32'(bfc_pkg::ID_HIST_READ))
                && (regAddr[31:8] == '0);
      pop = regRd && selHist && (state_q == bfc_pkg::CAP_FROZEN);
      rearm = regWr && selCfg && regWdata[bfc_pkg::CSR_HVALID];
      w1c = (regWr && (selCsr || selCfg)) ? regWdata[bfc_pkg::CSR_PAR:bfc_pkg::CSR_TXF] : '0;
      faultNow = (|faults) || busFaultIn;
   end

   // History entry: fields of this cycle, confirm added two cycles later
   always_comb begin
      entA_d = '0;
      entA_d[bfc_pkg::H_TAG_LSB-2 +: 3] = busTag;
      entA_d[bfc_pkg::H_ID_LSB-2 +: 5] = busId; // Source or destination per tag [RULE9]
      // Command cycles keep the function, data cycles the mask lines
      entA_d[bfc_pkg::H_MASK_LSB-2 +: 4] = (busTag == bfc_pkg::TAG_CMDADR) ? // [RULE12]
         busData[bfc_pkg::FUNC_MSB:bfc_pkg::FUNC_LSB] : busMask; // [RULE10] [RULE11] [RULE13]
      entA_d[bfc_pkg::H_REQ_LSB +: 16] = busReq; // [RULE17]
      entB_d = entA_q;
      entry = {entB_q[29:16], busConfirm, entB_q[15:0]}; // [RULE14]
      prime_d = (prime_q == 2'h2) ? prime_q : prime_q + 2'h1;
      histWr = (state_q == bfc_pkg::CAP_ARMED) && (prime_q == 2'h2); // [RULE6]
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         entA_q <= '0;
         entB_q <= '0;
         prime_q <= 2'h0;
      end else begin
         entA_q <= entA_d;
         entB_q <= entB_d;
         prime_q <= prime_d;
      end
   end

   // Capture state and latched fault bits; set wins over software clear
   always_comb begin
      state_d = state_q;
      flt_d = flt_q & ~w1c;
      if (state_q == bfc_pkg::CAP_ARMED && faultNow) begin
         state_d = bfc_pkg::CAP_FROZEN; // [RULE6]
         flt_d |= ({faults, myTransmitting} & FAULT_IMPL); // [RULE1] [RULE2] [RULE3] [RULE4]
      end else if (rearm) begin
         state_d = bfc_pkg::CAP_ARMED; // Held until software rearms [RULE23]
      end
      histValid_d = (state_d == bfc_pkg::CAP_FROZEN) &&
                    ((state_q == bfc_pkg::CAP_FROZEN) ? histValid_q : filled); // [RULE18]
      faultOut_d = |faults;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= bfc_pkg::CAP_ARMED;
         flt_q <= '0;
         histValid_q <= 1'b0;
         faultOut_q <= 1'b0;
      end else begin
         state_q <= state_d;
         flt_q <= flt_d;
         histValid_q <= histValid_d;
         faultOut_q <= faultOut_d;
      end
   end

   // Confirmation two cycles after a command addressed to us
   always_comb begin
      cnfPipe_d = bfc_pkg::CNF_NONE; // [RULE15]
      if (cmdHit) begin
         if (!funcOk) begin
            cnfPipe_d = bfc_pkg::CNF_ERROR; // [RULE16]
         end else if (busyIn) begin
            cnfPipe_d = bfc_pkg::CNF_BUSY; // [RULE16]
         end else begin
            cnfPipe_d = bfc_pkg::CNF_ACK; // [RULE15]
         end
      end
      cnf_d = cnfPipe_q; // [RULE14]
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnfPipe_q <= bfc_pkg::CNF_NONE;
         cnf_q <= bfc_pkg::CNF_NONE;
      end else begin
         cnfPipe_q <= cnfPipe_d;
         cnf_q <= cnf_d;
      end
   end

   // Read data, one cycle after the strobe; unmapped reads give zero
   always_comb begin
      csrWord = '0;
      csrWord[bfc_pkg::CSR_PAR:bfc_pkg::CSR_TXF] = flt_q & FAULT_IMPL; // [RULE4]
      rdata_d = '0;
      rvalid_d = regRd;
      if (regRd && selCsr) begin
         rdata_d = csrWord; // [RULE5]
      end else if (regRd && selCfg) begin
         rdata_d = csrWord;
         rdata_d[bfc_pkg::CSR_HVALID] = histValid_q; // [RULE18]
      end else if (regRd && selHist) begin
         rdata_d = histData; // [RULE7] [RULE8]
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign regRdata = rdata_q;
   assign regRvalid = rvalid_q;
   assign faultOut = faultOut_q;
   assign confirmOut = cnf_q;
   assign histValid = histValid_q;

   a_flt_latch: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE1]
      (state_q == bfc_pkg::CAP_ARMED && faults[4] && FAULT_IMPL[5]) |=> flt_q[5])
      else $error("parity fault bit not latched");
   a_txf_latch: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE3]
      (state_q == bfc_pkg::CAP_ARMED && faultNow && myTransmitting && FAULT_IMPL[0])
      |=> flt_q[0])
      else $error("transmitting status not latched");
   a_unimpl_zero: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE4]
      rvalid_q && $past(selCsr) |-> ((rdata_q[31:26] & ~FAULT_IMPL) == '0))
      else $error("unimplemented fault bit reads one");
   a_frozen_hold: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE23]
      (state_q == bfc_pkg::CAP_FROZEN && !rearm) |=> (state_q == bfc_pkg::CAP_FROZEN) && !histWr)
      else $error("frozen history was disturbed");
   a_cnf_ack: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE15]
      (cmdHit && funcOk && !busyIn) |-> ##2 (confirmOut == bfc_pkg::CNF_ACK))
      else $error("acknowledge not returned two cycles later");
   a_cnf_busy: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE16]
      (cmdHit && funcOk && busyIn) |-> ##2 (confirmOut == bfc_pkg::CNF_BUSY))
      else $error("busy not returned two cycles later");
   a_cnf_none: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE14]
      !cmdHit |-> ##2 (confirmOut == bfc_pkg::CNF_NONE))
      else $error("confirm driven without a command");
   a_hvalid_state: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE18]
      histValid |-> (state_q == bfc_pkg::CAP_FROZEN))
      else $error("history valid while armed");
   a_mxt_detect: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE22]
      (myTransmitting && myIdSent != busId && state_q == bfc_pkg::CAP_ARMED && FAULT_IMPL[1])
      |=> flt_q[1] && faultOut)
      else $error("multiple transmitter not flagged");

   c_fault_freeze: cover property (@(posedge core_clk) disable iff (sys_rst)
      state_q == bfc_pkg::CAP_ARMED ##1 state_q == bfc_pkg::CAP_FROZEN);
   c_valid_read: cover property (@(posedge core_clk) disable iff (sys_rst) histValid && pop);
   c_rearm: cover property (@(posedge core_clk) disable iff (sys_rst)
      state_q == bfc_pkg::CAP_FROZEN ##1 state_q == bfc_pkg::CAP_ARMED);
endmodule
`default_nettype wire

// ===== tb/bfc_peer_nodes.sv
`timescale 1ns/10ps
`default_nettype none
module bfc_peer_nodes (
   input wire logic core_clk,
   input wire logic ovUse,
   input wire logic [2:0] ovTag,
   input wire logic [4:0] ovId,
   input wire logic [31:0] ovData,
   input wire logic badPar,
   input wire logic [1:0] dutCnf,
   output logic [2:0] busTag,
   output logic [4:0] busId,
   output logic [3:0] busMask,
   output logic [31:0] busData,
   output logic [1:0] busParity,
   output logic [1:0] busConfirm,
   output logic [15:0] busReq
);
   logic [2:0] rTag;
   logic [4:0] rId;
   logic [3:0] rMask;
   logic [31:0] rData;
   logic [1:0] conA, conB;
   initial begin
      {rTag, rId, rMask, rData, busReq, conA, conB} = '0;
   end
   // Fresh foreign cycle each period; ids stop short of the node under test
   always @(negedge core_clk) begin
      rTag <= 3'($urandom);
      rId <= 5'($urandom_range(30));
      rMask <= 4'($urandom);
      rData <= $urandom & 32'hf7ff_ffff; // Never lands in the tested node's space
      busReq <= 16'($urandom);
   end
   // Bench-directed cycles replace ours for that period
   assign busTag = ovUse ? ovTag : rTag;
   assign busId = ovUse ? ovId : rId;
   assign busMask = ovUse ? 4'h0 : rMask;
   assign busData = ovUse ? ovData : rData;
   // Even parity per group; badPar spoils the header group on request
   assign busParity = {^busData, (^{busTag, busId, busMask}) ^ badPar};
   // Our own cycles get any answer code, two cycles on; wired-or with the node's
   always @(posedge core_clk) begin
      conA <= ovUse ? 2'h0 : 2'($urandom);
      conB <= conA;
   end
   assign busConfirm = conB | dutCnf;
endmodule
`default_nettype wire

// ===== tb/backplane_fault_capture_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module backplane_fault_capture_tb_top;
   logic core_clk, sys_rst, busFaultIn, myTransmitting, readWaiting, busyIn, badPar;
   logic regRd, regWr, regIdSpace, regRvalid, faultOut, histValid, ovUse;
   logic [2:0] busTag, ovTag;
   logic [4:0] busId, myIdSent, ovId;
   logic [3:0] busMask;
   logic [31:0] busData, regAddr, regWdata, regRdata, ovData;
   logic [1:0] busParity, busConfirm, confirmOut;
   logic [15:0] busReq;
   logic [31:0] lg[$];
   logic [1:0] cf[$];
   int error_cnt, tests_run, fIdx;
   localparam logic [4:0] OWN_NODE = 5'h1f;
   localparam logic [31:0] CFG = 32'(bfc_pkg::ID_PROC_CFG);
   localparam logic [31:0] HST = 32'(bfc_pkg::ID_HIST_READ);
   localparam logic [31:0] NODE_ADR = bfc_pkg::IO_BASE + bfc_pkg::NODE_STRIDE;
   localparam logic [31:0] HIT = {4'h0, NODE_ADR[29:13], 11'h0};
   localparam logic [31:0] EXP [5] = '{32'h8400_0000, 32'h4000_0000, 32'h2000_0000,
      32'h1000_0000, 32'h0c00_0000};
   localparam logic [3:0] FN [8] = '{bfc_pkg::FN_READ, bfc_pkg::FN_ILK_READ,
      bfc_pkg::FN_EXT_READ, bfc_pkg::FN_READ, 4'h3, 4'h3, bfc_pkg::FN_READ,
      bfc_pkg::FN_EXT_WRITE};
   localparam logic [1:0] ANS [8] = '{bfc_pkg::CNF_ACK, bfc_pkg::CNF_ACK, bfc_pkg::CNF_ACK,
      bfc_pkg::CNF_BUSY, bfc_pkg::CNF_ERROR, bfc_pkg::CNF_ERROR, bfc_pkg::CNF_NONE,
      bfc_pkg::CNF_ACK};
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   bfc_capture DUT (.core_clk(core_clk), .sys_rst(sys_rst), .busTag(busTag), .busId(busId),
      .busMask(busMask), .busData(busData), .busParity(busParity), .busConfirm(busConfirm),
      .busReq(busReq), .busFaultIn(busFaultIn), .myId(OWN_NODE), .myIdSent(myIdSent),
      .myTransmitting(myTransmitting), .readWaiting(readWaiting), .busyIn(busyIn),
      .regRd(regRd), .regWr(regWr), .regIdSpace(regIdSpace), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid), .faultOut(faultOut),
      .confirmOut(confirmOut), .histValid(histValid));
   bfc_peer_nodes PEER (.core_clk(core_clk), .ovUse(ovUse), .ovTag(ovTag), .ovId(ovId),
      .ovData(ovData), .badPar(badPar), .dutCnf(confirmOut), .busTag(busTag), .busId(busId),
      .busMask(busMask), .busData(busData), .busParity(busParity), .busConfirm(busConfirm),
      .busReq(busReq));
   // Reference log of every bus cycle; entry k takes its answer code from cycle k+2
   always @(posedge core_clk) begin
      if (!sys_rst) begin
         if (busFaultIn) fIdx = lg.size();
         lg.push_back({busTag, busId, 2'h0, (busTag == bfc_pkg::TAG_CMDADR) ?
            busData[31:28] : busMask, 2'h0, busReq});
         cf.push_back(busConfirm);
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Idle cycle after each read keeps the strobe from being raised twice at once
   task automatic rdc(input logic sp, input logic [31:0] a, input logic [31:0] exp);
      regIdSpace = sp;
      regAddr = a;
      regRd = 1'b1;
      @(negedge core_clk);
      regRd = 1'b0;
      chk({31'h0, regRvalid}, 32'h1);
      chk(regRdata, exp);
      @(negedge core_clk);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      regIdSpace = 1'b1;
      regAddr = a;
      regWdata = v;
      regWr = 1'b1;
      @(negedge core_clk);
      regWr = 1'b0;
   endtask
   task automatic dcyc(input logic [2:0] t, input logic [4:0] i, input logic [31:0] v,
      input logic tx, input logic [4:0] s);
      ovUse = 1'b1;
      ovTag = t;
      ovId = i;
      ovData = v;
      myTransmitting = tx;
      myIdSent = s;
      @(negedge core_clk);
   endtask
   task automatic idle(input int n);
      ovUse = 1'b0;
      badPar = 1'b0;
      myTransmitting = 1'b0;
      repeat (n) @(negedge core_clk);
   endtask
   task automatic results();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Run needs under two hundred cycles; a hang is cut well past that
   initial begin
      repeat (3000) @(posedge core_clk);
      error_cnt++;
      results();
   end
   initial begin
      void'($urandom(32'h63aef70d));
      {sys_rst, busFaultIn, myTransmitting, readWaiting, busyIn, badPar} = 6'h20;
      {regRd, regWr, regIdSpace, regAddr, regWdata, ovUse, ovTag, ovId, ovData, myIdSent} = '0;
      error_cnt = 0;
      tests_run = 0;
      fIdx = 0;
      repeat (16) @(negedge core_clk);
      sys_rst = 1'b0;
      // Clear out of reset; other slots and unmapped numbers read zero
      rdc(1'b1, CFG, 32'h0);
      rdc(1'b0, NODE_ADR, 32'h0);
      rdc(1'b1, 32'h20, 32'h0);
      rdc(1'b0, NODE_ADR + bfc_pkg::NODE_STRIDE, 32'h0);
      // Foreign traffic, then another node reports a fault and history freezes
      for (int i = 0; i < 30; i++) begin
         readWaiting = 1'($urandom);
         busyIn = 1'($urandom);
         @(negedge core_clk);
      end
      {readWaiting, busyIn, busFaultIn} = 3'h1;
      @(negedge core_clk);
      busFaultIn = 1'b0;
      @(negedge core_clk);
      chk({31'h0, histValid}, 32'h1);
      rdc(1'b1, CFG, 32'h0001_0000);
      for (int i = 0; i < 16; i++) begin
         rdc(1'b1, HST, lg[fIdx-17+i] | {14'h0, cf[fIdx-15+i], 16'h0});
      end
      // One fault kind per pass: rearm, provoke, check latch and that it holds
      for (int k = 0; k < 5; k++) begin
         wr(CFG, 32'hfc01_0000);
         rdc(1'b1, CFG, 32'h0);
         badPar = (k == 0);
         case (k)
            0: dcyc(3'h1, 5'h02, 32'h0, 1'b1, 5'h02);
            1: dcyc(bfc_pkg::TAG_CMDADR, 5'h02, HIT | {bfc_pkg::FN_WRITE, 28'h0}, 1'b0, 5'h0);
            2: dcyc(bfc_pkg::TAG_RDATA, OWN_NODE, 32'h0, 1'b0, 5'h0);
            3: dcyc(bfc_pkg::TAG_CMDADR, 5'h02, HIT | {bfc_pkg::FN_ILK_WRITE, 28'h0}, 1'b0, 5'h0);
            default: dcyc(3'h1, 5'h02, 32'h0, 1'b1, 5'h03);
         endcase
         badPar = 1'b0;
         if (k != 1) chk({31'h0, faultOut}, 32'h1);
         if (k == 1 || k == 3) dcyc(k == 1 ? 3'h1 : bfc_pkg::TAG_WDATA, 5'h02, 32'h0, 1'b0, 5'h0);
         if (k == 1) chk({31'h0, faultOut}, 32'h1);
         idle(1);
         rdc(1'b0, NODE_ADR, EXP[k]);
         rdc(1'b1, CFG, EXP[k]);
         badPar = 1'b1;
         @(negedge core_clk);
         idle(1);
         rdc(1'b0, NODE_ADR, EXP[k]);
      end
      // Commands at this node and one for another slot: answer two cycles on, by function and busy state
      wr(CFG, 32'hfc01_0000);
      for (int k = 0; k < 8; k++) begin
         busyIn = (k == 3 || k == 5);
         dcyc(bfc_pkg::TAG_CMDADR, 5'h02, (k == 6 ? HIT ^ 32'h800 : HIT) | {FN[k], 28'h0},
            1'b0, 5'h0);
         idle(1);
         chk({30'h0, confirmOut}, {30'h0, ANS[k]});
         idle(1);
         chk({30'h0, confirmOut}, 32'h0);
      end
      results();
   end
endmodule
`default_nettype wire
